// >>> core/rcg_pkg.sv
// Shared constants and types for the rolling-code replay guard.
package rcg_pkg;
    // Widths of the rolling code, the signature and the link key.
    localparam int CODE_W = 32;
    localparam int SIG_W = 32;
    localparam int SHORT_SIG_W = 24;
    localparam int KEY_W = 128;
    localparam int TRY_W = 8;
    localparam int PEER_W_DEFAULT = 2;

    // Values after reset and the end of the code sequence.
    localparam logic [CODE_W-1:0] CODE_RESET = 32'h00000000;
    localparam logic [CODE_W-1:0] CODE_LAST = 32'hffffffff;
    localparam logic [CODE_W-1:0] CODE_STEP = 32'h00000001;
    localparam logic [SIG_W-1:0] SIG_RESET = 32'h00000000;
    localparam logic [KEY_W-1:0] KEY_RESET = 128'h0;
    localparam logic [TRY_W-1:0] TRY_RESET = 8'h00;
    localparam logic [TRY_W-1:0] TRY_STEP = 8'h01;

    // Look-ahead count tried beyond the expected code.
    localparam logic [TRY_W-1:0] WINDOW_DEFAULT = 8'h10;

    // Link table selector on the configuration port.
    localparam logic DIR_IN = 1'b0;
    localparam logic DIR_OUT = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TX,
        ST_RX
    } rcg_state_type;
endpackage

// >>> core/rcg_replay_guard.sv
// Rolling-code replay guard with per-peer link tables and look-ahead.
`timescale 1ns/1ps
module rcg_replay_guard #(
    parameter int PEER_W = rcg_pkg::PEER_W_DEFAULT,
    parameter logic [rcg_pkg::TRY_W-1:0] WINDOW = rcg_pkg::WINDOW_DEFAULT
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic cfg_we_in,
    input wire logic cfg_dir_in,
    input wire logic [PEER_W-1:0] cfg_peer_in,
    input wire logic [rcg_pkg::CODE_W-1:0] cfg_code_in,
    input wire logic [rcg_pkg::KEY_W-1:0] cfg_key_in,
    input wire logic cfg_implicit_in,
    input wire logic forward_en_in,
    input wire logic tx_req_in,
    input wire logic [PEER_W-1:0] tx_peer_in,
    input wire logic rx_req_in,
    input wire logic [PEER_W-1:0] rx_peer_in,
    input wire logic [rcg_pkg::CODE_W-1:0] rx_code_in,
    input wire logic [rcg_pkg::SIG_W-1:0] rx_sig_in,
    input wire logic rx_sig24_in,
    input wire logic sig_done_in,
    input wire logic [rcg_pkg::SIG_W-1:0] sig_value_in,
    output logic sig_req_out,
    output logic [rcg_pkg::CODE_W-1:0] sig_code_out,
    output logic [rcg_pkg::KEY_W-1:0] sig_key_out,
    output logic busy_out,
    output logic tx_done_out,
    output logic tx_err_out,
    output logic [rcg_pkg::CODE_W-1:0] tx_code_out,
    output logic [rcg_pkg::SIG_W-1:0] tx_sig_out,
    output logic rx_ok_out,
    output logic rx_fail_out,
    output logic rx_forward_out,
    output logic [rcg_pkg::CODE_W-1:0] rx_code_out
);
    import rcg_pkg::*;

    localparam int PEERS = 1 << PEER_W;

    // Outbound table: next code to send and key, per peer.
    logic [CODE_W-1:0] out_code_reg [PEERS];
    logic [KEY_W-1:0] out_key_reg [PEERS];
    logic [PEERS-1:0] out_valid_reg;
    // Inbound table: next acceptable code, key and mode, per peer.
    logic [CODE_W-1:0] in_code_reg [PEERS];
    logic [KEY_W-1:0] in_key_reg [PEERS];
    logic [PEERS-1:0] in_valid_reg;
    logic [PEERS-1:0] in_implicit_reg;

    rcg_state_type state_reg;
    logic [PEER_W-1:0] peer_reg;
    logic [CODE_W-1:0] cand_reg;
    logic [TRY_W-1:0] tries_reg;
    logic [SIG_W-1:0] rx_sig_reg;
    logic rx_sig24_reg;

    logic idle;
    logic cfg_take;
    logic tx_take;
    logic rx_take;
    logic tx_ok;
    logic rx_start_ok;
    logic sig_match;
    logic rx_accept;
    logic rx_retry;
    logic rx_reject;

    assign idle = (state_reg == ST_IDLE);
    // Configuration wins over requests; requests while busy are ignored.
    assign cfg_take = idle && cfg_we_in;
    assign tx_take = idle && !cfg_we_in && tx_req_in;
    assign rx_take = idle && !cfg_we_in && !tx_req_in && rx_req_in;
    assign tx_ok = out_valid_reg[tx_peer_in];
    // An explicit code below the next acceptable one is a replay.
    assign rx_start_ok = in_valid_reg[rx_peer_in] &&
        (in_implicit_reg[rx_peer_in] ||
         (rx_code_in >= in_code_reg[rx_peer_in]));

    // Short signatures compare only their low bytes.
    always_comb begin
        if (rx_sig24_reg) begin
            sig_match = (sig_value_in[SHORT_SIG_W-1:0] ==
                         rx_sig_reg[SHORT_SIG_W-1:0]);
        end else begin
            sig_match = (sig_value_in == rx_sig_reg);
        end
    end

    assign rx_accept = (state_reg == ST_RX) && sig_done_in && sig_match;
    // Look-ahead only in implicit mode, and never past the last code.
    assign rx_retry = (state_reg == ST_RX) && sig_done_in && !sig_match &&
        in_implicit_reg[peer_reg] && (tries_reg < WINDOW) &&
        (cand_reg != CODE_LAST);
    assign rx_reject = (state_reg == ST_RX) && sig_done_in && !sig_match &&
        !rx_retry;

    // Link tables; both directions are kept apart, keys may be equal.
    always_ff @(posedge clock_in) begin
        if (cfg_take && cfg_dir_in == DIR_OUT) begin
            out_code_reg[cfg_peer_in] <= cfg_code_in;
            out_key_reg[cfg_peer_in] <= cfg_key_in;
        end else if (tx_take && tx_ok) begin
            out_code_reg[tx_peer_in] <= out_code_reg[tx_peer_in] +
                CODE_STEP;
        end
        if (cfg_take && cfg_dir_in == DIR_IN) begin
            in_code_reg[cfg_peer_in] <= cfg_code_in;
            in_key_reg[cfg_peer_in] <= cfg_key_in;
        end else if (rx_accept) begin
            in_code_reg[peer_reg] <= cand_reg + CODE_STEP;
        end
    end

    // Entry validity; an entry that used its last code is retired.
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            out_valid_reg <= '0;
            in_valid_reg <= '0;
            in_implicit_reg <= '0;
        end else begin
            if (cfg_take && cfg_dir_in == DIR_OUT) begin
                out_valid_reg[cfg_peer_in] <= 1'b1;
            end else if (tx_take && tx_ok &&
                         out_code_reg[tx_peer_in] == CODE_LAST) begin
                out_valid_reg[tx_peer_in] <= 1'b0;
            end
            if (cfg_take && cfg_dir_in == DIR_IN) begin
                in_valid_reg[cfg_peer_in] <= 1'b1;
                in_implicit_reg[cfg_peer_in] <= cfg_implicit_in;
            end else if (rx_accept && cand_reg == CODE_LAST) begin
                in_valid_reg[peer_reg] <= 1'b0;
            end
        end
    end

    // Sequencer for sign and verify attempts.
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            state_reg <= ST_IDLE;
            peer_reg <= '0;
            cand_reg <= CODE_RESET;
            tries_reg <= TRY_RESET;
            rx_sig_reg <= SIG_RESET;
            rx_sig24_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (tx_take && tx_ok) begin
                        peer_reg <= tx_peer_in;
                        cand_reg <= out_code_reg[tx_peer_in];
                        state_reg <= ST_TX;
                    end else if (rx_take && rx_start_ok) begin
                        peer_reg <= rx_peer_in;
                        tries_reg <= TRY_RESET;
                        rx_sig_reg <= rx_sig_in;
                        rx_sig24_reg <= rx_sig24_in;
                        if (in_implicit_reg[rx_peer_in]) begin
                            cand_reg <= in_code_reg[rx_peer_in];
                        end else begin
                            cand_reg <= rx_code_in;
                        end
                        state_reg <= ST_RX;
                    end
                end
                ST_TX: begin
                    if (sig_done_in) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_RX: begin
                    if (rx_retry) begin
                        cand_reg <= cand_reg + CODE_STEP;
                        tries_reg <= tries_reg + TRY_STEP;
                    end else if (sig_done_in) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Signature engine request: the code is the nonce, with the link key.
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            sig_req_out <= 1'b0;
            sig_code_out <= CODE_RESET;
            sig_key_out <= KEY_RESET;
        end else begin
            sig_req_out <= 1'b0;
            if (tx_take && tx_ok) begin
                sig_req_out <= 1'b1;
                sig_code_out <= out_code_reg[tx_peer_in];
                sig_key_out <= out_key_reg[tx_peer_in];
            end else if (rx_take && rx_start_ok) begin
                sig_req_out <= 1'b1;
                sig_key_out <= in_key_reg[rx_peer_in];
                if (in_implicit_reg[rx_peer_in]) begin
                    sig_code_out <= in_code_reg[rx_peer_in];
                end else begin
                    sig_code_out <= rx_code_in;
                end
            end else if (rx_retry) begin
                sig_req_out <= 1'b1;
                sig_code_out <= cand_reg + CODE_STEP;
            end
        end
    end

    // Results; the key stays on sig_key_out for the decryptor after a match.
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            busy_out <= 1'b0;
            tx_done_out <= 1'b0;
            tx_err_out <= 1'b0;
            tx_code_out <= CODE_RESET;
            tx_sig_out <= SIG_RESET;
            rx_ok_out <= 1'b0;
            rx_fail_out <= 1'b0;
            rx_forward_out <= 1'b0;
            rx_code_out <= CODE_RESET;
        end else begin
            busy_out <= (tx_take && tx_ok) || (rx_take && rx_start_ok) ||
                (!idle && !(sig_done_in && !rx_retry));
            tx_done_out <= (state_reg == ST_TX) && sig_done_in;
            tx_err_out <= tx_take && !tx_ok;
            rx_ok_out <= rx_accept;
            rx_fail_out <= rx_reject || (rx_take && !rx_start_ok);
            rx_forward_out <= forward_en_in &&
                (rx_reject || (rx_take && !rx_start_ok));
            if ((state_reg == ST_TX) && sig_done_in) begin
                // Code and signature leave together for one telegram.
                tx_code_out <= cand_reg;
                tx_sig_out <= sig_value_in;
            end
            if (rx_accept) begin
                rx_code_out <= cand_reg;
            end
        end
    end
endmodule

// >>> sim/rcg_replay_guard_bench.sv
// Self-checking bench for the rolling-code replay guard.
`timescale 1ns/1ps
module rcg_replay_guard_bench;
    import rcg_pkg::*;
    localparam logic [TRY_W-1:0] WIN = 8'h02;
    localparam logic [CODE_W-1:0] B = 32'h64;
    localparam logic [KEY_W-1:0] K1 = 128'h1234;
    localparam logic [KEY_W-1:0] K2 = 128'h9c3e5a71;
    logic clock_in = 1'b0;
    logic resetn_in, cfg_we_in, cfg_dir_in, cfg_implicit_in, forward_en_in;
    logic tx_req_in, rx_req_in, rx_sig24_in, sig_done_in, slow;
    logic [1:0] cfg_peer_in, tx_peer_in, rx_peer_in;
    logic [CODE_W-1:0] cfg_code_in, rx_code_in, sig_code_out;
    logic [CODE_W-1:0] tx_code_out, rx_code_out;
    logic [KEY_W-1:0] cfg_key_in, sig_key_out;
    logic [SIG_W-1:0] rx_sig_in, sig_value_in, tx_sig_out;
    logic sig_req_out, busy_out, tx_done_out, tx_err_out;
    logic rx_ok_out, rx_fail_out, rx_forward_out;
    logic [3:0] r;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    always #4 clock_in = ~clock_in;
    rcg_replay_guard #(.PEER_W(2), .WINDOW(WIN)) dut (.*);
    rcg_sig_engine model (.clock_in(clock_in), .resetn_in(resetn_in),
        .slow_in(slow), .req_in(sig_req_out), .code_in(sig_code_out),
        .key_in(sig_key_out), .done_out(sig_done_in),
        .value_out(sig_value_in));
    function automatic logic [31:0] sig_of(logic [31:0] c, logic [127:0] k);
        return k[31:0] ^ {c[15:0], c[31:16]};
    endfunction
    task automatic cmp(input logic [31:0] exp, input logic [31:0] act);
        checked++;
        if (act !== exp) begin
            errors++;
            $display("Error at %0t: expected %h, got %h", $time, exp, act);
        end
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic await();
        // Refusals answer one cycle after the take, so look at once.
        r = {tx_done_out, tx_err_out, rx_ok_out, rx_fail_out};
        for (int n = 0; n < 100 && r == 4'h0; n++) begin
            @(negedge clock_in);
            r = {tx_done_out, tx_err_out, rx_ok_out, rx_fail_out};
        end
        if (r == 4'h0) begin
            errors++;
            $display("Error at %0t: expected %h, got %h", $time, 4'hf, r);
        end
    endtask
    task automatic cfg(logic d, logic [1:0] p, logic [31:0] c, logic [127:0] k,
                       logic im);
        {cfg_dir_in, cfg_peer_in, cfg_code_in, cfg_key_in} = {d, p, c, k};
        {cfg_implicit_in, cfg_we_in} = {im, 1'b1};
        @(negedge clock_in);
        cfg_we_in = 1'b0;
    endtask
    task automatic do_tx(logic [1:0] p);
        {tx_peer_in, tx_req_in} = {p, 1'b1};
        @(negedge clock_in);
        tx_req_in = 1'b0;
        await();
    endtask
    task automatic do_rx(logic [1:0] p, logic [31:0] c, logic [31:0] s,
                         logic s24);
        {rx_peer_in, rx_code_in, rx_sig_in, rx_sig24_in} = {p, c, s, s24};
        rx_req_in = 1'b1;
        @(negedge clock_in);
        rx_req_in = 1'b0;
        await();
    endtask
    task automatic test_tx();
        cfg(DIR_OUT, 2'h1, 32'h5, K1, 1'b0);
        do_tx(2'h1);
        cmp(32'h5, tx_code_out);
        cmp(sig_of(32'h5, K1), tx_sig_out);
        slow = 1'b1;
        do_tx(2'h1);
        cmp(32'h6, tx_code_out);
        do_tx(2'h2);
        cmp(32'h4, {28'h0, r});
        cfg(DIR_OUT, 2'h3, 32'hffffffff, K2, 1'b0);
        do_tx(2'h3);
        cmp(32'hffffffff, tx_code_out);
        do_tx(2'h3);
        cmp(32'h4, {28'h0, r});
        $display("test_tx finished");
    endtask
    task automatic test_implicit();
        cfg(DIR_IN, 2'h1, B, K2, 1'b1);
        forward_en_in = 1'b1;
        do_rx(2'h1, 32'h0, sig_of(B + WIN, K2), 1'b0);
        cmp(B + WIN, rx_code_out);
        cmp(K2[31:0], sig_key_out[31:0]);
        do_rx(2'h1, 32'h0, sig_of(B + WIN + 1, K2) ^ 32'hab000000, 1'b1);
        cmp(B + WIN + 1, rx_code_out);
        do_rx(2'h1, 32'h0, sig_of(B + WIN, K2), 1'b0);
        cmp(32'h1, {28'h0, r});
        cmp(32'h1, {31'h0, rx_forward_out});
        {forward_en_in, slow} = 2'b00;
        do_rx(2'h1, 32'h0, sig_of(B + 2 * WIN + 3, K2), 1'b0);
        cmp(32'h2, {27'h0, r, rx_forward_out});
        do_rx(2'h1, 32'h0, sig_of(B + WIN + 2, K2), 1'b0);
        cmp(B + WIN + 2, rx_code_out);
        $display("test_implicit finished");
    endtask
    task automatic test_explicit();
        cfg(DIR_IN, 2'h2, 32'h14, K1, 1'b0);
        do_rx(2'h2, 32'h13, sig_of(32'h13, K1), 1'b0);
        cmp(32'h1, {28'h0, r});
        do_rx(2'h2, 32'h16, sig_of(32'h16, K1), 1'b0);
        cmp(32'h16, rx_code_out);
        do_rx(2'h2, 32'h17, sig_of(32'h18, K1), 1'b0);
        cmp(32'h1, {28'h0, r});
        $display("test_explicit finished");
    endtask
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        resetn_in = 1'b0;
        {cfg_we_in, cfg_dir_in, cfg_implicit_in, forward_en_in} = '0;
        {tx_req_in, rx_req_in, rx_sig24_in, slow} = '0;
        {cfg_peer_in, tx_peer_in, rx_peer_in} = '0;
        {cfg_code_in, rx_code_in, cfg_key_in, rx_sig_in} = '0;
        repeat (8) @(negedge clock_in);
        resetn_in = 1'b1;
        test_tx();
        test_implicit();
        test_explicit();
        print_verdict();
    end
endmodule

// >>> sim/rcg_replay_guard_monitor.sv
// Port assertions for the rolling-code replay guard.
`timescale 1ns/1ps
module rcg_replay_guard_monitor (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic rx_sig24_in,
    input wire logic [rcg_pkg::SIG_W-1:0] rx_sig_in,
    input wire logic sig_done_in,
    input wire logic [rcg_pkg::SIG_W-1:0] sig_value_in,
    input wire logic sig_req_out,
    input wire logic [rcg_pkg::CODE_W-1:0] sig_code_out,
    input wire logic busy_out,
    input wire logic tx_done_out,
    input wire logic [rcg_pkg::CODE_W-1:0] tx_code_out,
    input wire logic [rcg_pkg::SIG_W-1:0] tx_sig_out,
    input wire logic rx_ok_out,
    input wire logic rx_fail_out,
    input wire logic rx_forward_out,
    input wire logic [rcg_pkg::CODE_W-1:0] rx_code_out
);
    import rcg_pkg::*;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    sequence s_retry; sig_done_in ##1 sig_req_out; endsequence
    sequence s_tx_end; sig_done_in ##1 tx_done_out; endsequence
    property p_answer;
        sig_done_in |=> tx_done_out || rx_ok_out || rx_fail_out || sig_req_out;
    endproperty
    property p_busy; sig_req_out |-> busy_out ##1 !sig_req_out; endproperty
    property p_tx_sig;
        s_tx_end |-> tx_sig_out == $past(sig_value_in)
            && tx_code_out == sig_code_out;
    endproperty
    property p_rx_ok;
        rx_ok_out |-> $past(sig_done_in) && rx_code_out == sig_code_out;
    endproperty
    property p_rx_sig;
        rx_ok_out |-> $past(sig_value_in[23:0]) == $past(rx_sig_in[23:0])
            && ($past(rx_sig24_in) || $past(sig_value_in) == $past(rx_sig_in));
    endproperty
    property p_retry;
        s_retry |-> sig_code_out == $past(sig_code_out) + CODE_STEP;
    endproperty
    property p_fwd; rx_forward_out |-> rx_fail_out; endproperty
    property p_excl; !(rx_ok_out && rx_fail_out); endproperty
    a_answer: assert property (p_answer)
        else $error("no step after answer");
    a_busy: assert property (p_busy)
        else $error("bad request pulse");
    a_tx_sig: assert property (p_tx_sig)
        else $error("tx result wrong");
    a_rx_ok: assert property (p_rx_ok)
        else $error("rx code wrong");
    a_rx_sig: assert property (p_rx_sig)
        else $error("accepted bad sig");
    a_retry: assert property (p_retry)
        else $error("retry code wrong");
    a_fwd: assert property (p_fwd)
        else $error("forward without fail");
    a_excl: assert property (p_excl)
        else $error("ok and fail");
endmodule
bind rcg_replay_guard rcg_replay_guard_monitor mon (.*);

// >>> sim/rcg_sig_engine.sv
// Signature engine model that answers each request after a short or long wait.
`timescale 1ns/1ps
module rcg_sig_engine (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic slow_in,
    input wire logic req_in,
    input wire logic [31:0] code_in,
    input wire logic [127:0] key_in,
    output logic done_out,
    output logic [31:0] value_out
);
    logic [31:0] sig_reg;
    logic [31:0] mix;
    logic [3:0] wait_reg;
    logic busy_reg;
    assign mix = key_in[31:0] ^
        {code_in[15:0], code_in[31:16]};
    always_ff @(posedge clock_in) begin
        done_out <= 1'b0;
        if (!resetn_in) begin
            busy_reg <= 1'b0;
        end else if (req_in) begin
            busy_reg <= 1'b1;
            wait_reg <= slow_in ? 4'h5 : 4'h0;
            sig_reg <= mix;
        end else if (busy_reg && wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
        end else if (busy_reg) begin
            busy_reg <= 1'b0;
            done_out <= 1'b1;
        end
    end
    // Off the answer cycle the value is inverted so stale data never matches.
    assign value_out = done_out ? sig_reg : ~sig_reg;
endmodule
